// ===== design/flash_host_ctrl.sv
`timescale 1ns/1ps
`include "flash_host_regs.svh"
// Overview of operation
// R1 - write enable precedes lock write and erases
// R2 - lock write: opcode, three address, one data
// R3 - select rises right after lock data byte
// R4 - device clears write latch quickly after lock
// R5 - lock byte: zeros, lock-down b1, write-lock b0
// R6 - page erase: opcode plus three address bytes
// R7 - select rises right after last address byte
// R8 - device ignores top five address bits
// R9 - device busy during erase, clears latch
// R10 - device skips erase of protected page
// R11 - device skips sector with protected page
// R12 - device rejects commands during internal cycle
// R13 - subsector erase accepts any inner address
// R14 - reset pin aborts erase, then wait delay
// R15 - opcode-only commands, select rises after eight
// R16 - device skips bulk erase when anything protected
// R17 - select stays low for whole command
// R18 - deselect puts idle device in standby
// R19 - sleep entered after entry delay
// R20 - while asleep only release is sent
// R21 - no extra clocks after release opcode
// R22 - select held high through release delay
// R23 - power-up clears all lock bits
// R24 - reset pulse clears all lock bits
// R25 - without write latch, device ignores commands; model ignores only lock and erase
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter logic [7:0]  HALF_DIV          = 8'h02,
   parameter logic [7:0]  OP_WRITE_ENABLE   = `OP_WRITE_ENABLE,
   parameter logic [7:0]  OP_LOCK_WRITE     = `OP_LOCK_WRITE,
   parameter logic [7:0]  OP_PAGE_ERASE     = `OP_PAGE_ERASE,
   parameter logic [7:0]  OP_SUBSECTOR_ERASE = `OP_SUBSECTOR_ERASE,
   parameter logic [7:0]  OP_SECTOR_ERASE   = `OP_SECTOR_ERASE,
   parameter logic [7:0]  OP_BULK_ERASE     = `OP_BULK_ERASE,
   parameter logic [7:0]  OP_SLEEP          = `OP_SLEEP,
   parameter logic [7:0]  OP_WAKE           = `OP_WAKE,
   parameter logic [31:0] PAGE_CLEAR_CYCLES =
      32'(`US_CYCLES(`PAGE_CLEAR_TIME_US)),
   parameter logic [31:0] SUBSECTOR_CLEAR_CYCLES =
      32'(`US_CYCLES(`SUBSECTOR_CLEAR_TIME_US)),
   parameter logic [31:0] SECTOR_CLEAR_CYCLES =
      32'(`US_CYCLES(`SECTOR_CLEAR_TIME_US)),
   parameter logic [31:0] WHOLE_ARRAY_CLEAR_CYCLES =
      32'(`US_CYCLES(`WHOLE_ARRAY_CLEAR_TIME_US))
) (
   // clocking
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   // user command port
   input  wire logic        cmdValid,
   output logic             cmdReady,
   input  wire cmd_t        cmdOp,
   input  wire logic [23:0] cmdAddr,
   input  wire logic [1:0]  cmdLock,
   input  wire logic        abortReq,
   output logic             cmdDone,
   output logic             busy,
   output logic             asleep,
   // flash pins
   output logic             selectN,
   output logic             serialClk,
   output logic             serialOut,
   output logic             resetN
);
   // ------------------------------------------------------------
   // short waits
   // ------------------------------------------------------------
   localparam logic [31:0] SEL_HIGH_CYC =
      32'(`NS_CYCLES(`SELECT_HIGH_TIME_NS));
   localparam logic [31:0] RST_PULSE_CYC =
      32'(`NS_CYCLES(`RESET_PULSE_TIME_NS));
   localparam logic [31:0] RST_SEL_CYC =
      32'(`US_CYCLES(`RESET_TO_SELECT_DELAY_US));
   localparam logic [31:0] SLEEP_IN_CYC =
      32'(`US_CYCLES(`SLEEP_ENTRY_DELAY_US));
   localparam logic [31:0] SLEEP_OUT_CYC =
      32'(`US_CYCLES(`SLEEP_EXIT_DELAY_US));

   if (HALF_DIV < 8'h01 || PAGE_CLEAR_CYCLES < SEL_HIGH_CYC ||
       SUBSECTOR_CLEAR_CYCLES < SEL_HIGH_CYC ||
       SECTOR_CLEAR_CYCLES < SEL_HIGH_CYC ||
       WHOLE_ARRAY_CLEAR_CYCLES < SEL_HIGH_CYC) begin : g_chk
      $error("divider or wait counts out of range");
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   function automatic logic needs_wren(input cmd_t op);
      needs_wren = (op != CMD_SLEEP) && (op != CMD_WAKE);
   endfunction : needs_wren

   function automatic logic [7:0] opcode_of(input cmd_t op);
      case (op)
         CMD_LOCK_WRITE:      opcode_of = OP_LOCK_WRITE;
         CMD_PAGE_ERASE:      opcode_of = OP_PAGE_ERASE;
         CMD_SUBSECTOR_ERASE: opcode_of = OP_SUBSECTOR_ERASE;
         CMD_SECTOR_ERASE:    opcode_of = OP_SECTOR_ERASE;
         CMD_BULK_ERASE:      opcode_of = OP_BULK_ERASE;
         CMD_SLEEP:           opcode_of = OP_SLEEP;
         default:             opcode_of = OP_WAKE;
      endcase
   endfunction : opcode_of

   function automatic logic [5:0] bits_of(input cmd_t op);
      case (op)
         CMD_LOCK_WRITE:      bits_of = `LOCK_FRAME_BITS; // [R2]
         CMD_PAGE_ERASE,
         CMD_SUBSECTOR_ERASE,
         CMD_SECTOR_ERASE:    bits_of = `ADDR_FRAME_BITS; // [R7]
         default:             bits_of = `OPCODE_BITS;     // [R15]
      endcase
   endfunction : bits_of

   function automatic logic [31:0] wait_of(input cmd_t op);
      case (op)
         CMD_PAGE_ERASE:      wait_of = PAGE_CLEAR_CYCLES;
         CMD_SUBSECTOR_ERASE: wait_of = SUBSECTOR_CLEAR_CYCLES;
         CMD_SECTOR_ERASE:    wait_of = SECTOR_CLEAR_CYCLES;
         CMD_BULK_ERASE:      wait_of = WHOLE_ARRAY_CLEAR_CYCLES;
         CMD_SLEEP:           wait_of = SLEEP_IN_CYC;
         CMD_WAKE:            wait_of = SLEEP_OUT_CYC;  // [R22]
         default:             wait_of = SEL_HIGH_CYC;
      endcase
   endfunction : wait_of

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   host_state_t s_q;
   host_state_t s_d;
   logic        shDone;

   assign cmdReady = ce && s_q.st == ST_IDLE && !abortReq &&
                     (!s_q.asleep || cmdOp == CMD_WAKE); // [R20]

   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.start = 1'b0;
         s_d.abort = 1'b0;
         s_d.done  = 1'b0;
         if (abortReq && s_q.st != ST_RST_LOW) begin
            // reset pin cuts any running erase short [R14]
            s_d.st    = ST_RST_LOW;
            s_d.rstN  = 1'b0;
            s_d.selN  = 1'b1;
            s_d.abort = 1'b1;
            s_d.cnt   = RST_PULSE_CYC;
         end else begin
            case (s_q.st)
               ST_IDLE: begin
                  if (cmdValid && cmdReady) begin
                     s_d.op    = cmdOp;
                     s_d.addr  = cmdAddr;
                     s_d.lock  = cmdLock;
                     s_d.selN  = 1'b0;
                     s_d.start = 1'b1;
                     if (needs_wren(cmdOp)) begin // [R1]
                        s_d.st    = ST_SHIFT_WREN;
                        s_d.nBits = `OPCODE_BITS;
                        s_d.frame = {OP_WRITE_ENABLE, 32'h00000000};
                     end else begin
                        s_d.st    = ST_SHIFT_CMD;
                        s_d.nBits = bits_of(cmdOp);
                        s_d.frame = {opcode_of(cmdOp), 32'h00000000};
                     end
                  end
               end
               ST_SHIFT_WREN: begin
                  if (shDone) begin
                     s_d.st   = ST_GAP_WREN;
                     s_d.selN = 1'b1;
                     s_d.cnt  = SEL_HIGH_CYC;
                  end
               end
               ST_GAP_WREN: begin
                  if (s_q.cnt == 32'h00000000) begin
                     s_d.st    = ST_SHIFT_CMD;
                     s_d.selN  = 1'b0; // held low to the end [R17]
                     s_d.start = 1'b1;
                     s_d.nBits = bits_of(s_q.op);
                     s_d.frame = {opcode_of(s_q.op), s_q.addr,
                                  6'h00, s_q.lock}; // [R5]
                  end else begin
                     s_d.cnt = s_q.cnt - 32'h00000001;
                  end
               end
               ST_SHIFT_CMD: begin
                  if (shDone) begin
                     // rise at once, else the command is dropped [R3]
                     s_d.st   = ST_WAIT;
                     s_d.selN = 1'b1; // [R7] [R15]
                     s_d.cnt  = wait_of(s_q.op);
                  end
               end
               ST_WAIT: begin
                  // timed wait instead of polling the busy flag
                  if (s_q.cnt == 32'h00000000) begin
                     s_d.st   = ST_IDLE;
                     s_d.done = 1'b1;
                     if (s_q.op == CMD_SLEEP) begin
                        s_d.asleep = 1'b1;
                     end else if (s_q.op == CMD_WAKE) begin
                        s_d.asleep = 1'b0;
                     end
                  end else begin
                     s_d.cnt = s_q.cnt - 32'h00000001;
                  end
               end
               ST_RST_LOW: begin
                  if (s_q.cnt == 32'h00000000) begin
                     s_d.st   = ST_RST_WAIT;
                     s_d.rstN = 1'b1;
                     s_d.cnt  = RST_SEL_CYC;
                  end else begin
                     s_d.cnt = s_q.cnt - 32'h00000001;
                  end
               end
               ST_RST_WAIT: begin
                  // device comes back in standby [R14]
                  if (s_q.cnt == 32'h00000000) begin
                     s_d.st     = ST_IDLE;
                     s_d.asleep = 1'b0;
                     s_d.done   = 1'b1;
                  end else begin
                     s_d.cnt = s_q.cnt - 32'h00000001;
                  end
               end
               default: begin
                  s_d.st = ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.op   <= CMD_WAKE;
         s_q.selN <= 1'b1;
         s_q.rstN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   spi_frame_shifter #(
      .HALF_DIV (HALF_DIV)
   ) u_shifter (
      .clock     (clock),
      .nrst      (nrst),
      .ce        (ce),
      .start     (s_q.start),
      // same edge as the select rise, so no clock with select high [R17]
      .abort     (s_d.abort),
      .nBits     (s_q.nBits),
      .frame     (s_q.frame),
      .done      (shDone),
      .serialClk (serialClk),
      .serialOut (serialOut)
   );

   assign selectN = s_q.selN;
   assign resetN  = s_q.rstN;
   assign cmdDone = s_q.done;
   assign busy    = s_q.st != ST_IDLE;
   assign asleep  = s_q.asleep;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   AST_WREN_FIRST: assert property ( // [R1]
      ($rose(s_q.st == ST_SHIFT_CMD) && needs_wren(s_q.op))
      |-> $past(s_q.st) == ST_GAP_WREN)
      else $error("erase or lock sent without write enable");
   AST_LOCK_FRAME: assert property ( // [R2]
      ($rose(s_q.st == ST_SHIFT_CMD) && s_q.op == CMD_LOCK_WRITE)
      |-> s_q.nBits == 6'h28)
      else $error("lock frame length wrong");
   AST_LOCK_BYTE: assert property ( // [R5]
      ($rose(s_q.st == ST_SHIFT_CMD) && s_q.op == CMD_LOCK_WRITE)
      |-> s_q.frame[7:2] == 6'h00 && s_q.frame[1:0] == s_q.lock)
      else $error("lock data byte malformed");
   AST_ERASE_FRAME: assert property ( // [R7]
      ($rose(s_q.st == ST_SHIFT_CMD) && needs_wren(s_q.op) &&
       s_q.op != CMD_LOCK_WRITE && s_q.op != CMD_BULK_ERASE)
      |-> s_q.nBits == 6'h20)
      else $error("addressed erase frame length wrong");
   AST_OPCODE_ONLY: assert property ( // [R15]
      ($rose(s_q.st == ST_SHIFT_CMD) && (s_q.op == CMD_BULK_ERASE ||
       s_q.op == CMD_SLEEP || s_q.op == CMD_WAKE))
      |-> s_q.nBits == 6'h08)
      else $error("opcode-only frame length wrong");
   AST_SELECT_AFTER_LAST: assert property ( // [R3]
      (shDone && ce && s_q.st == ST_SHIFT_CMD) |=> selectN)
      else $error("select did not rise after last bit");
   AST_SELECT_LOW_CLOCKING: assert property ( // [R17]
      serialClk |-> !selectN)
      else $error("serial clock with select high");
   AST_RESET_DESELECTS: assert property ( // [R14]
      (!resetN) |-> selectN && !serialClk)
      else $error("device selected during reset pulse");
   AST_SLEEP_REFUSES: assert property ( // [R20]
      (s_q.asleep && cmdOp != CMD_WAKE) |-> !cmdReady)
      else $error("command accepted while asleep");
   AST_WAKE_HOLD: assert property ( // [R22]
      ($rose(s_q.st == ST_WAIT) && s_q.op == CMD_WAKE)
      |-> s_q.cnt == SLEEP_OUT_CYC && selectN)
      else $error("release delay not honoured");

   COV_ERASE: cover property (s_q.done && s_q.op == CMD_SECTOR_ERASE);
   COV_LOCK: cover property (s_q.done && s_q.op == CMD_LOCK_WRITE);
   COV_WAKE: cover property ($fell(s_q.asleep));
   COV_ABORT: cover property (!resetN && $past(s_q.st) == ST_WAIT);
endmodule : flash_host_ctrl

// ===== design/flash_host_regs.svh
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// ------------------------------------------------------------
// clock and frame shapes
// ------------------------------------------------------------
`define CLOCK_PERIOD_NS          50
`define OPCODE_BITS              6'h08
`define ADDR_FRAME_BITS          6'h20
`define LOCK_FRAME_BITS          6'h28
`define LOCK_DOWN_BIT            1
`define WRITE_LOCK_BIT           0
// ------------------------------------------------------------
// opcode defaults, arbitrary values
// ------------------------------------------------------------
`define OP_WRITE_ENABLE          8'h0A
`define OP_LOCK_WRITE            8'h1B
`define OP_PAGE_ERASE            8'h2C
`define OP_SUBSECTOR_ERASE       8'h3D
`define OP_SECTOR_ERASE          8'h4E
`define OP_BULK_ERASE            8'h5F
`define OP_SLEEP                 8'h6A
`define OP_WAKE                  8'h7B
// ------------------------------------------------------------
// timing, in the units named
// ------------------------------------------------------------
`define SELECT_HIGH_TIME_NS      100
`define RESET_PULSE_TIME_NS      200
`define RESET_TO_SELECT_DELAY_US 30
`define SLEEP_ENTRY_DELAY_US     3
`define SLEEP_EXIT_DELAY_US      30
`define PAGE_CLEAR_TIME_US       10000
`define SUBSECTOR_CLEAR_TIME_US  150000
`define SECTOR_CLEAR_TIME_US     1000000
`define WHOLE_ARRAY_CLEAR_TIME_US 10000000
`define NS_CYCLES(t) (((t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define US_CYCLES(t) \
   ((64'd1000 * (t) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// ===== design/flash_host_pkg.sv
package flash_host_pkg;
   typedef enum logic [2:0] {
      CMD_LOCK_WRITE, CMD_PAGE_ERASE, CMD_SUBSECTOR_ERASE,
      CMD_SECTOR_ERASE, CMD_BULK_ERASE, CMD_SLEEP, CMD_WAKE
   } cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SHIFT_WREN, ST_GAP_WREN, ST_SHIFT_CMD, ST_WAIT,
      ST_RST_LOW, ST_RST_WAIT
   } state_t;
   typedef struct packed {
      state_t      st;
      cmd_t        op;
      logic [23:0] addr;
      logic [1:0]  lock;
      logic [31:0] cnt;
      logic        asleep;
      logic        selN;
      logic        rstN;
      logic        start;
      logic        abort;
      logic [5:0]  nBits;
      logic [39:0] frame;
      logic        done;
   } host_state_t;
   typedef struct packed {
      logic        active;
      logic        sclk;
      logic [7:0]  div;
      logic [5:0]  left;
      logic [39:0] sr;
      logic        done;
   } shift_state_t;
endpackage : flash_host_pkg

// ===== design/spi_frame_shifter.sv
`timescale 1ns/1ps
module spi_frame_shifter
   import flash_host_pkg::*;
#(
   parameter logic [7:0] HALF_DIV = 8'h02
) (
   // clocking
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   // frame request
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic [5:0]  nBits,
   input  wire logic [39:0] frame,
   output logic             done,
   // serial pins
   output logic             serialClk,
   output logic             serialOut
);
   if (HALF_DIV < 8'h01) begin : g_chk
      $error("HALF_DIV must be at least one");
   end

   shift_state_t s_q;
   shift_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.done = 1'b0;
         if (abort) begin
            s_d.active = 1'b0;
            s_d.sclk   = 1'b0;
         end else if (start) begin
            s_d.active = 1'b1;
            s_d.sclk   = 1'b0;
            s_d.div    = 8'h00;
            s_d.left   = nBits;
            s_d.sr     = frame;
         end else if (s_q.active) begin
            s_d.div = s_q.div + 8'h01;
            if (s_q.div == HALF_DIV - 8'h01) begin
               s_d.div = 8'h00;
               if (!s_q.sclk) begin
                  s_d.sclk = 1'b1;
               end else begin
                  // no clock after the last bit [R21]
                  s_d.sclk = 1'b0;
                  s_d.sr   = {s_q.sr[38:0], 1'b0};
                  s_d.left = s_q.left - 6'h01;
                  if (s_q.left == 6'h01) begin
                     s_d.active = 1'b0;
                     s_d.done   = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done      = s_q.done;
   assign serialClk = s_q.sclk;
   assign serialOut = s_q.sr[39];

   AST_NO_TRAILING_CLOCK: assert property (@(posedge clock) // [R21]
      disable iff (!nrst) s_q.done |-> !s_q.active && !s_q.sclk)
      else $error("clock still running after last bit");
endmodule : spi_frame_shifter

// ===== verification/flash_device_model.sv
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_device_model #(
   parameter int BUSY_CYC = 6,
   parameter int RSEL_CYC = 600
) (
   // power-on and sampling clock
   input  wire logic        clock,
   input  wire logic        porN,
   // device pins
   input  wire logic        selectN,
   input  wire logic        serialClk,
   input  wire logic        serialIn,
   input  wire logic        resetN,
   // observed state
   output logic             writeLatch,
   output logic             busyCycle,
   output logic             sleeping,
   output logic [7:0]       lockByte,
   output logic [23:0]      lastAddr,
   output logic [7:0]       lastOp,
   output logic [5:0]       lastBits,
   output logic [7:0]       nExec,
   output logic [7:0]       nErr
);
   logic [39:0] sr;
   logic [5:0]  bits;
   logic        sckPrev;
   logic        selPrev;
   logic [7:0]  op;
   logic [9:0]  cnt;
   logic [9:0]  since;
   logic        go;
   logic        erase;

   always_comb begin
      case (bits)
         6'h08:   op = sr[7:0];
         6'h20:   op = sr[31:24];
         default: op = sr[39:32];
      endcase
   end

   // --------------------------------------------------------
   // pins sampled on the system clock, edges found by history
   // --------------------------------------------------------
   always @(posedge clock or negedge porN or negedge resetN) begin
      if (!porN || !resetN) begin
         {writeLatch, busyCycle, sleeping, bits, cnt} <= '0;
         lockByte <= 8'h00;
         since    <= porN ? 10'h000 : RSEL_CYC[9:0];
         sckPrev  <= 1'b0;
         selPrev  <= 1'b1;
         sr       <= '0;
         if (!porN) begin
            {lastAddr, lastOp, lastBits, nExec, nErr} <= '0;
         end
      end else begin
         sckPrev <= serialClk;
         selPrev <= selectN;
         if (since != RSEL_CYC[9:0]) since <= since + 10'h001;
         if (!selectN && selPrev && since != RSEL_CYC[9:0]) begin
            nErr <= nErr + 8'h01;
         end
         if (cnt != 10'h000) cnt <= cnt - 10'h001;
         else busyCycle <= 1'b0;
         if (!selectN && serialClk && !sckPrev) begin
            sr   <= {sr[38:0], serialIn};
            bits <= bits + 6'h01;
         end
         if (selectN && !selPrev) begin
            bits     <= 6'h00;
            lastBits <= bits;
            lastOp   <= op;
            erase = 1'b0;
            // busy: everything dropped, release too; asleep: everything but release dropped
            go = !busyCycle && (!sleeping || op == `OP_WAKE);
            if (go) begin
               case (op)
                  `OP_WRITE_ENABLE:
                     if (bits == `OPCODE_BITS) writeLatch <= 1'b1;
                  `OP_LOCK_WRITE:
                     if (bits == `LOCK_FRAME_BITS && writeLatch) begin
                        lockByte   <= sr[7:0];
                        lastAddr   <= sr[31:8];
                        writeLatch <= 1'b0;
                     end
                  `OP_PAGE_ERASE, `OP_SUBSECTOR_ERASE, `OP_SECTOR_ERASE:
                     if (bits == `ADDR_FRAME_BITS && writeLatch &&
                         !lockByte[0]) begin
                        lastAddr <= {5'h00, sr[18:0]};
                        erase = 1'b1;
                     end
                  `OP_BULK_ERASE:
                     if (bits == `OPCODE_BITS && writeLatch && !lockByte[0])
                        erase = 1'b1;
                  `OP_SLEEP:
                     if (bits == `OPCODE_BITS) sleeping <= 1'b1;
                  `OP_WAKE:
                     if (bits == `OPCODE_BITS) sleeping <= 1'b0;
                  default: ;
               endcase
            end
            if (erase) begin
               busyCycle  <= 1'b1;
               cnt        <= BUSY_CYC[9:0];
               writeLatch <= 1'b0;
               nExec      <= nExec + 8'h01;
            end
         end
      end
   end
endmodule : flash_device_model

// ===== verification/serial_flash_erase_lock_powerdown_test.sv
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module serial_flash_erase_lock_powerdown_test
   import flash_host_pkg::*;
;
   logic clock, nrst, ce, cmdValid, cmdReady, abortReq, cmdDone, busy;
   logic asleep, selectN, serialClk, serialOut, resetN;
   cmd_t        cmdOp;
   logic [23:0] cmdAddr, lastAddr;
   logic [1:0]  cmdLock;
   logic        writeLatch, busyCycle, sleeping;
   logic [7:0]  lockByte, lastOp, nExec, nErr;
   logic [5:0]  lastBits;
   int          nMismatch, numChecks;

   // short erase waits keep the run brief
   flash_host_ctrl #(.PAGE_CLEAR_CYCLES(32'h8),
      .SUBSECTOR_CLEAR_CYCLES(32'h8), .SECTOR_CLEAR_CYCLES(32'h8),
      .WHOLE_ARRAY_CLEAR_CYCLES(32'h8)) dut (.clock(clock), .nrst(nrst),
      .ce(ce), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdAddr(cmdAddr), .cmdLock(cmdLock), .abortReq(abortReq),
      .cmdDone(cmdDone), .busy(busy), .asleep(asleep), .selectN(selectN),
      .serialClk(serialClk), .serialOut(serialOut), .resetN(resetN));
   flash_device_model flash (.clock(clock), .porN(nrst),
      .selectN(selectN), .serialClk(serialClk), .serialIn(serialOut),
      .resetN(resetN), .writeLatch(writeLatch), .busyCycle(busyCycle),
      .sleeping(sleeping), .lockByte(lockByte), .lastAddr(lastAddr),
      .lastOp(lastOp), .lastBits(lastBits), .nExec(nExec), .nErr(nErr));

   always #25 clock = ~clock;

   // --------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic offer(input cmd_t op, input logic [23:0] a,
                        input logic [1:0] l);
      int i;
      @(negedge clock);
      cmdOp = op;
      cmdAddr = a;
      cmdLock = l;
      cmdValid = 1'b1;
      for (i = 0; i < 50 && cmdReady !== 1'b1; i++) @(negedge clock);
      @(negedge clock);
      cmdValid = 1'b0;
   endtask : offer

   task automatic wait_done();
      int   i;
      logic bad;
      bad = 1'b0;
      for (i = 0; i < 2000 && cmdDone !== 1'b1; i++) begin
         if (cmdReady !== 1'b0) bad = 1'b1;
         @(negedge clock);
      end
      check(32'(bad), 32'h0);
      check(32'(cmdDone), 32'h1);
      check(32'(busy), 32'h0);
   endtask : wait_done

   task automatic run(input cmd_t op, input logic [23:0] a,
                      input logic [1:0] l);
      offer(op, a, l);
      wait_done();
   endtask : run

   // --------------------------------------------------------
   // scenarios
   // --------------------------------------------------------
   task automatic test_lock();
      run(CMD_LOCK_WRITE, 24'hF81234, 2'b10);
      check(32'(lockByte), 32'h02);
      check(32'(lastOp), 32'(`OP_LOCK_WRITE));
      check(32'(lastBits), 32'h28);
      check(32'(lastAddr), 32'hF81234);
      check(32'(writeLatch), 32'h0);
      $display("test lock write finished");
   endtask : test_lock

   task automatic test_erase();
      cmd_t ops[4] = '{CMD_PAGE_ERASE, CMD_SUBSECTOR_ERASE,
                       CMD_SECTOR_ERASE, CMD_BULK_ERASE};
      logic [7:0] codes[4] = '{`OP_PAGE_ERASE, `OP_SUBSECTOR_ERASE,
                               `OP_SECTOR_ERASE, `OP_BULK_ERASE};
      logic [7:0] n;
      for (int k = 0; k < 4; k++) begin
         n = nExec;
         run(ops[k], 24'hFA5A5A, 2'b00);
         check(32'(nExec), 32'(n + 8'h01));
         check(32'(lastOp), 32'(codes[k]));
         check(32'(lastBits), (k == 3) ? 32'h08 : 32'h20);
         check(32'(busyCycle), 32'h0);
         if (k < 3) check(32'(lastAddr), 32'h025A5A);
      end
      $display("test erase family finished");
   endtask : test_erase

   task automatic test_protect();
      logic [7:0] n;
      run(CMD_LOCK_WRITE, 24'h000100, 2'b01);
      n = nExec;
      run(CMD_PAGE_ERASE, 24'h000100, 2'b00);
      run(CMD_BULK_ERASE, 24'h000000, 2'b00);
      check(32'(nExec), 32'(n));
      run(CMD_LOCK_WRITE, 24'h000100, 2'b00);
      check(32'(lockByte), 32'h00);
      $display("test protection finished");
   endtask : test_protect

   task automatic test_sleep();
      run(CMD_SLEEP, 24'h000000, 2'b00);
      check(32'(asleep), 32'h1);
      check(32'(sleeping), 32'h1);
      @(negedge clock);
      cmdOp = CMD_PAGE_ERASE;
      @(negedge clock);
      check(32'(cmdReady), 32'h0);
      run(CMD_WAKE, 24'h000000, 2'b00);
      check(32'(asleep), 32'h0);
      check(32'(sleeping), 32'h0);
      check(32'(lastBits), 32'h08);
      $display("test sleep and wake finished");
   endtask : test_sleep

   task automatic test_abort();
      int i;
      run(CMD_LOCK_WRITE, 24'h000000, 2'b10);
      offer(CMD_SUBSECTOR_ERASE, 24'h012345, 2'b00);
      for (i = 0; i < 400 && busyCycle !== 1'b1; i++) @(negedge clock);
      abortReq = 1'b1;
      @(negedge clock);
      abortReq = 1'b0;
      wait_done();
      check(32'(lockByte), 32'h00);
      check(32'(busyCycle), 32'h0);
      run(CMD_LOCK_WRITE, 24'h000000, 2'b11);
      check(32'(lockByte), 32'h03);
      check(32'(nErr), 32'h00);
      $display("test abort finished");
   endtask : test_abort

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // --------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      cmdValid = 1'b0;
      cmdOp = CMD_LOCK_WRITE;
      cmdAddr = 24'h000000;
      cmdLock = 2'b00;
      abortReq = 1'b0;
      nMismatch = 0;
      numChecks = 0;
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      test_lock();
      test_erase();
      test_protect();
      test_sleep();
      test_abort();
      give_verdict();
   end

   // whole run is a few thousand cycles; far beyond means a hang
   initial begin
      repeat (20000) @(posedge clock);
      nMismatch++;
      give_verdict();
   end
endmodule : serial_flash_erase_lock_powerdown_test
